// ### core/memfn_regs.svh
// Constants for the paged memory layer: command codes, field positions, reset values and fixed patterns.
`ifndef MEMFN_REGS_SVH
`define MEMFN_REGS_SVH

// Memory function command codes.
`define CMD_WRITE_SP 8'h0F
`define CMD_READ_SP 8'hAA
`define CMD_COPY_SP 8'h5A
`define CMD_READ_MEM 8'hF0
`define CMD_READ_MEM_CTR 8'hA5

// Memory geometry.
`define MEM_FIRST_ADDR 9'h000
`define MEM_LAST_ADDR 9'h1FF
`define PAGE_LAST_OFFSET 5'h1F
`define LAST_PAGE 4'hF
`define COUNTED_PAGE_HI 2'h3

// Ending offset/status byte layout.
`define ES_AA_BIT 7
`define ES_ZERO_BIT 6
`define ES_PF_BIT 5
`define ES_END_MSB 4

// Reset values of the address and status registers.
`define TA_RESET 8'h00
`define END_RESET 5'h00

// Fixed byte patterns.
`define TAMPER_PATTERN 32'h55555555
`define COUNTER_NONE 32'hFFFFFFFF
`define COPY_DONE_BYTE 8'hAA
`define IDLE_BYTE 8'hFF

// CRC16 with x16+x15+x2+1, reflected for lsb-first shifting.
`define CRC16_POLY_REV 16'hA001
`define CRC16_CLEAR 16'h0000

// Step counts inside multi-byte phases.
`define HDR_LAST 6'h02
`define AUTH_LAST 6'h02
`define CRC_LAST 6'h01
`define TAIL_CRC_LO 6'h08
`define TAIL_LAST 6'h09

`endif

// ### core/memfn_pkg.sv
// Types shared by the paged memory layer and its link-side users.
package memfn_pkg;

    // One received byte from the bit-slot layer, or a partial-byte marker.
    typedef struct packed {
        logic valid;
        logic partial;
        logic [7:0] data;
    } rx_byte_t;

    // One byte offered to the bit-slot layer for read slots.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } tx_byte_t;

    // Command sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR_LO,
        ST_ADDR_HI,
        ST_WS_DATA,
        ST_WS_CRC,
        ST_RS_HDR,
        ST_RS_DATA,
        ST_CP_AUTH,
        ST_CP_COPY,
        ST_CP_DONE,
        ST_RM_DATA,
        ST_RMC_DATA,
        ST_RMC_TAIL,
        ST_ONES
    } state_t;

endpackage : memfn_pkg

// ### core/paged_memory_counter_reader.sv
// Memory function layer: pages, scratchpad, write-cycle counters and the counter-augmented read.
`timescale 1ns/10ps
`include "memfn_regs.svh"

// Contract
// RQ1: Data memory is sixteen 32-byte pages at byte addresses 0000H to 01FFH.
// RQ2: A separate 32-byte scratchpad buffers data headed for the pages.
// RQ3: Four write-cycle counters, for pages 12 to 15, read only by the counter read.
// RQ4: Address arrives low byte then high byte into the two target address registers.
// RQ5: Status byte: accepted flag bit 7, zero bit 6, partial flag bit 5, offset 4..0.
// RQ6: Command A5H plus two address bytes starts the counter-augmented read.
// RQ7: That read returns page bytes from the start address up to the page end.
// RQ8: At page end follow the 32-bit counter, 32 tamper bits and a 16-bit CRC.
// RQ9: Tamper bits are the fixed pattern 55555555H and cannot be written.
// RQ10: Pages without a counter return all ones in the counter position.
// RQ11: After each CRC the next page follows from byte zero, through the last page.
// RQ12: First page CRC covers command, both address bytes, data, counter and tamper bits.
// RQ13: Later page CRCs restart clear and cover only data, counter and tamper bits.
// RQ14: After the last page CRC every read slot returns ones until reset.
// RQ15: A reset pulse abandons the counter-augmented read at any point.
// RQ16: Scratchpad write stores at the offset, records it as ending offset, increments.
// RQ17: A write reaching offset 11111b lets the master read the CRC16 back.
// RQ18: Scratchpad read sends address, status, then bytes from the start offset upward.
// RQ19: Copy 5AH runs only if both address bytes and status match exactly.
// RQ20: Scratchpad read past the scratchpad end returns all-ones bytes.
// RQ21: The accepted flag is cleared only by a scratchpad write command.
// RQ22: CRC16 x16+x15+x2+1, lsb first, sent inverted, low byte first.
module paged_memory_counter_reader (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic bus_reset,
    input wire memfn_pkg::rx_byte_t rx_in,
    input wire logic tx_ready,
    output memfn_pkg::tx_byte_t tx_out_ff,
    output logic buf_ready_ff
);

    // Sequencer, addressing and status state.
    memfn_pkg::state_t st_ff;
    logic [7:0] cmd_ff, ta_lo_ff, ta_hi_ff, es_byte, emit_byte, feed_byte, auth_exp;
    logic [5:0] cnt_ff;
    logic [4:0] off_ff, end_ff;
    logic [8:0] addr_ff;
    logic match_ff, pf_ff, aa_ff;
    // Storage, the CRC generator and the second entry of the output buffer.
    logic [7:0] mem_ff [0:511];
    logic [7:0] sp_ff [0:31];
    logic [31:0] ctr_ff [0:3];
    logic [15:0] crc_ff;
    memfn_pkg::tx_byte_t skid_ff;
    // Strobes and selected values shared by the processes.
    logic abort, rx_take, emit_want, emit_go, feed_en, auth_ok, copy_last, tail_last_page;
    logic [3:0] copy_page;
    logic [31:0] ctr_val;
    logic [79:0] tail_bytes;
    // Advances the CRC16 by one byte, least significant bit first.
    function automatic logic [15:0] crc16_step(input logic [15:0] crc_in, input logic [7:0] din);
        logic [15:0] c;
        c = crc_in;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ din[i]) begin
                c = (c >> 1) ^ `CRC16_POLY_REV; // RQ22
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction : crc16_step

    // Status byte as it is read back and compared; bit 6 is always zero.
    assign es_byte = {aa_ff, 1'b0, pf_ff, end_ff}; // RQ5

    // A reset pulse aborts any command except a copy in progress, which ignores it.
    assign abort = bus_reset && (st_ff != memfn_pkg::ST_CP_COPY); // RQ15

    // Bytes are accepted from the link only in states that expect master data.
    assign rx_take = rx_in.valid && !abort &&
        (st_ff == memfn_pkg::ST_IDLE || st_ff == memfn_pkg::ST_ADDR_LO ||
         st_ff == memfn_pkg::ST_ADDR_HI || st_ff == memfn_pkg::ST_WS_DATA ||
         st_ff == memfn_pkg::ST_CP_AUTH);
    // A byte leaves only when the buffer can hold it, so a stalled reader stalls the sequencer.
    assign emit_go = emit_want && buf_ready_ff && !abort;

    // Copy targets the page named by the target address.
    assign copy_page = {ta_hi_ff[0], ta_lo_ff[7:5]};
    assign copy_last = (st_ff == memfn_pkg::ST_CP_COPY) && (off_ff == end_ff);
    // Page counter or all ones, and the page tail laid out byte by byte in the order it is sent.
    assign ctr_val = (addr_ff[8:7] == `COUNTED_PAGE_HI) ? ctr_ff[addr_ff[6:5]] : `COUNTER_NONE; // RQ3 RQ10
    assign tail_bytes = {~crc_ff, `TAMPER_PATTERN, ctr_val}; // RQ8 RQ9 RQ22
    assign tail_last_page = (addr_ff[8:5] == `LAST_PAGE);
    // Expected authorization byte for each step, which is also the header byte of a scratchpad read.
    assign auth_exp = (cnt_ff[1:0] == 2'h0) ? ta_lo_ff : ((cnt_ff[1:0] == 2'h1) ? ta_hi_ff : es_byte);
    // Every byte must match and the match must hold from the first byte on.
    assign auth_ok = (rx_in.data == auth_exp) && ((cnt_ff == 6'h00) || match_ff); // RQ19
    // Selects the byte offered for the next read slots.
    always_comb begin
        emit_want = 1'b1;
        emit_byte = `IDLE_BYTE;
        case (st_ff)
            memfn_pkg::ST_WS_CRC: begin
                emit_byte = (cnt_ff == `CRC_LAST) ? ~crc_ff[15:8] : ~crc_ff[7:0]; // RQ22
            end
            memfn_pkg::ST_RS_HDR: begin
                emit_byte = auth_exp; // RQ18
            end
            memfn_pkg::ST_RS_DATA: begin
                emit_byte = sp_ff[cnt_ff[4:0]]; // RQ18
            end
            memfn_pkg::ST_CP_DONE: begin
                emit_byte = `COPY_DONE_BYTE;
            end
            memfn_pkg::ST_RM_DATA, memfn_pkg::ST_RMC_DATA: begin
                emit_byte = mem_ff[addr_ff]; // RQ7
            end
            memfn_pkg::ST_RMC_TAIL: begin
                emit_byte = tail_bytes[{cnt_ff[3:0], 3'h0} +: 8]; // RQ8 RQ9 RQ22
            end
            memfn_pkg::ST_ONES: begin
                emit_byte = `IDLE_BYTE; // RQ14 RQ20
            end
            default: begin
                emit_want = 1'b0;
            end
        endcase
    end

    // Chooses which byte, if any, enters the CRC: master bytes after the command, then page bytes and the counter and tamper bytes of the tail.
    assign feed_en = (rx_take && (st_ff == memfn_pkg::ST_ADDR_LO || st_ff == memfn_pkg::ST_ADDR_HI ||
                                  st_ff == memfn_pkg::ST_WS_DATA)) || // RQ12
        (emit_go && (st_ff == memfn_pkg::ST_RMC_DATA ||
                     (st_ff == memfn_pkg::ST_RMC_TAIL && cnt_ff < `TAIL_CRC_LO))); // RQ13
    assign feed_byte = rx_take ? rx_in.data : emit_byte;
    // Command sequencer.
    always_ff @(posedge clk_sys) begin
        if (srst || abort) begin
            st_ff <= memfn_pkg::ST_IDLE; // RQ15
            cmd_ff <= 8'h00;
            cnt_ff <= 6'h00;
            off_ff <= 5'h00;
            addr_ff <= `MEM_FIRST_ADDR;
            match_ff <= 1'b0;
        end else begin
            case (st_ff)
                memfn_pkg::ST_IDLE: begin
                    if (rx_take) begin
                        cmd_ff <= rx_in.data;
                        cnt_ff <= 6'h00;
                        case (rx_in.data)
                            `CMD_WRITE_SP, `CMD_READ_MEM, `CMD_READ_MEM_CTR: st_ff <= memfn_pkg::ST_ADDR_LO; // RQ6
                            `CMD_READ_SP: st_ff <= memfn_pkg::ST_RS_HDR;
                            `CMD_COPY_SP: st_ff <= memfn_pkg::ST_CP_AUTH;
                            default: st_ff <= memfn_pkg::ST_ONES;
                        endcase
                    end
                end
                memfn_pkg::ST_ADDR_LO: begin
                    if (rx_take) begin
                        st_ff <= memfn_pkg::ST_ADDR_HI; // RQ4
                    end
                end
                memfn_pkg::ST_ADDR_HI: begin
                    if (rx_take) begin
                        addr_ff <= {rx_in.data[0], ta_lo_ff}; // RQ1
                        off_ff <= ta_lo_ff[4:0];
                        case (cmd_ff)
                            `CMD_WRITE_SP: st_ff <= memfn_pkg::ST_WS_DATA;
                            `CMD_READ_MEM: st_ff <= memfn_pkg::ST_RM_DATA;
                            default: st_ff <= memfn_pkg::ST_RMC_DATA;
                        endcase
                    end
                end
                memfn_pkg::ST_WS_DATA: begin
                    if (rx_in.partial) begin
                        st_ff <= memfn_pkg::ST_ONES;
                    end else if (rx_take) begin
                        off_ff <= off_ff + 5'h01; // RQ16
                        if (off_ff == `PAGE_LAST_OFFSET) begin
                            st_ff <= memfn_pkg::ST_WS_CRC; // RQ17
                            cnt_ff <= 6'h00;
                        end
                    end
                end
                memfn_pkg::ST_WS_CRC: begin
                    if (emit_go) begin
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff == `CRC_LAST) begin
                            st_ff <= memfn_pkg::ST_ONES;
                        end
                    end
                end
                memfn_pkg::ST_RS_HDR: begin
                    if (emit_go) begin
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff == `HDR_LAST) begin
                            st_ff <= memfn_pkg::ST_RS_DATA;
                            cnt_ff <= {1'b0, ta_lo_ff[4:0]}; // RQ18
                        end
                    end
                end
                memfn_pkg::ST_RS_DATA: begin
                    if (emit_go) begin
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff[4:0] == `PAGE_LAST_OFFSET) begin
                            st_ff <= memfn_pkg::ST_ONES; // RQ20
                        end
                    end
                end
                memfn_pkg::ST_CP_AUTH: begin
                    if (rx_take) begin
                        match_ff <= auth_ok;
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff == `AUTH_LAST) begin
                            off_ff <= ta_lo_ff[4:0];
                            st_ff <= auth_ok ? memfn_pkg::ST_CP_COPY : memfn_pkg::ST_ONES; // RQ19
                        end
                    end
                end
                memfn_pkg::ST_CP_COPY: begin
                    off_ff <= off_ff + 5'h01;
                    if (copy_last) begin
                        st_ff <= memfn_pkg::ST_CP_DONE;
                    end
                end
                memfn_pkg::ST_RM_DATA: begin
                    if (emit_go) begin
                        addr_ff <= addr_ff + 9'h001;
                        if (addr_ff == `MEM_LAST_ADDR) begin
                            st_ff <= memfn_pkg::ST_ONES;
                        end
                    end
                end
                memfn_pkg::ST_RMC_DATA: begin
                    if (emit_go) begin
                        if (addr_ff[4:0] == `PAGE_LAST_OFFSET) begin
                            st_ff <= memfn_pkg::ST_RMC_TAIL; // RQ7
                            cnt_ff <= 6'h00;
                        end else begin
                            addr_ff <= addr_ff + 9'h001;
                        end
                    end
                end
                memfn_pkg::ST_RMC_TAIL: begin
                    if (emit_go) begin
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff == `TAIL_LAST) begin
                            cnt_ff <= 6'h00;
                            if (tail_last_page) begin
                                st_ff <= memfn_pkg::ST_ONES; // RQ14
                            end else begin
                                st_ff <= memfn_pkg::ST_RMC_DATA; // RQ11
                                addr_ff <= addr_ff + 9'h001;
                            end
                        end
                    end
                end
                memfn_pkg::ST_CP_DONE, memfn_pkg::ST_ONES: begin
                    st_ff <= st_ff;
                end
                default: begin
                    st_ff <= memfn_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Target address and ending offset/status registers.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ta_lo_ff <= `TA_RESET;
            ta_hi_ff <= `TA_RESET;
            end_ff <= `END_RESET;
            pf_ff <= 1'b0;
            aa_ff <= 1'b0;
        end else begin
            if (rx_take && st_ff == memfn_pkg::ST_ADDR_LO) begin
                ta_lo_ff <= rx_in.data; // RQ4
            end
            if (rx_take && st_ff == memfn_pkg::ST_ADDR_HI) begin
                ta_hi_ff <= {7'h00, rx_in.data[0]}; // RQ4
                if (cmd_ff == `CMD_WRITE_SP) begin
                    pf_ff <= 1'b0;
                    aa_ff <= 1'b0; // RQ21
                end
            end
            if (rx_take && st_ff == memfn_pkg::ST_WS_DATA) begin
                end_ff <= off_ff; // RQ16
            end
            if (rx_in.partial && st_ff == memfn_pkg::ST_WS_DATA && !abort) begin
                pf_ff <= 1'b1;
            end
            if (rx_take && st_ff == memfn_pkg::ST_CP_AUTH && cnt_ff == `AUTH_LAST && auth_ok) begin
                aa_ff <= 1'b1; // RQ19
            end
        end
    end

    // CRC generator: cleared at each command and again between pages of the counter read.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            crc_ff <= `CRC16_CLEAR;
        end else if (rx_take && st_ff == memfn_pkg::ST_IDLE) begin
            crc_ff <= crc16_step(`CRC16_CLEAR, rx_in.data); // RQ12
        end else if (emit_go && st_ff == memfn_pkg::ST_RMC_TAIL && cnt_ff == `TAIL_LAST) begin
            crc_ff <= `CRC16_CLEAR; // RQ13
        end else if (feed_en) begin
            crc_ff <= crc16_step(crc_ff, feed_byte); // RQ22
        end
    end

    // Scratchpad storage.
    always_ff @(posedge clk_sys) begin
        if (rx_take && st_ff == memfn_pkg::ST_WS_DATA) begin
            sp_ff[off_ff] <= rx_in.data; // RQ2 RQ16
        end
    end

    // Page memory, written one scratchpad byte per cycle during a copy.
    always_ff @(posedge clk_sys) begin
        if (st_ff == memfn_pkg::ST_CP_COPY) begin
            mem_ff[{copy_page, off_ff}] <= sp_ff[off_ff]; // RQ1
        end
    end

    // Write-cycle counters for the top four pages; they saturate instead of rolling over.
    generate
        for (genvar i = 0; i < 4; i++) begin : g_ctr
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    ctr_ff[i] <= 32'h00000000;
                end else if (copy_last && copy_page[3:2] == `COUNTED_PAGE_HI &&
                             copy_page[1:0] == 2'(i) && ctr_ff[i] != `COUNTER_NONE) begin
                    ctr_ff[i] <= ctr_ff[i] + 32'h00000001; // RQ3
                end
            end
        end
    endgenerate

    // Two-entry output buffer: a head register feeding the link and a skid register behind it.
    always_ff @(posedge clk_sys) begin
        if (srst || abort) begin
            tx_out_ff <= '0;
            skid_ff <= '0;
        end else if (!tx_out_ff.valid || tx_ready) begin
            if (skid_ff.valid) begin
                tx_out_ff <= skid_ff;
                skid_ff.valid <= emit_go;
                skid_ff.data <= emit_byte;
            end else begin
                tx_out_ff.valid <= emit_go;
                tx_out_ff.data <= emit_byte;
            end
        end else if (emit_go) begin
            skid_ff.valid <= 1'b1;
            skid_ff.data <= emit_byte;
        end
    end
    // Space is known one cycle ahead: ready means the skid entry is empty at the next edge.
    always_ff @(posedge clk_sys) begin
        if (srst || abort) begin
            buf_ready_ff <= 1'b1;
        end else begin
            buf_ready_ff <= (!tx_out_ff.valid || tx_ready) ? !(skid_ff.valid && emit_go) : !(skid_ff.valid || emit_go);
        end
    end
endmodule : paged_memory_counter_reader

// ### bench/memfn_chk.sv
// Checker for the byte ports of the paged memory layer.
`timescale 1ns/10ps
`include "memfn_regs.svh"
module memfn_chk (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic bus_reset,
    input wire memfn_pkg::rx_byte_t rx_in,
    input wire logic tx_ready,
    input wire memfn_pkg::tx_byte_t tx_out_ff,
    input wire logic buf_ready_ff
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    // Opening steps of the read, counter read and copy commands.
    sequence s_rsp;
        bus_reset ##1 (rx_in.valid && rx_in.data == `CMD_READ_SP);
    endsequence
    sequence s_rmc;
        bus_reset ##1 (rx_in.valid && rx_in.data == `CMD_READ_MEM_CTR) ##2 rx_in.valid ##2 rx_in.valid;
    endsequence
    sequence s_cp;
        bus_reset ##1 (rx_in.valid && rx_in.data == `CMD_COPY_SP) ##2 rx_in.valid ##2 rx_in.valid
            ##2 rx_in.valid;
    endsequence
    // Answer timing, buffer behaviour and flushing.
    property p_rsp;
        s_rsp |-> !tx_out_ff.valid ##1 !tx_out_ff.valid ##1 tx_out_ff.valid;
    endproperty
    a_rsp: assert property (p_rsp) else $error("read answer mistimed");
    property p_rmc;
        s_rmc |-> !tx_out_ff.valid ##1 !tx_out_ff.valid ##1 tx_out_ff.valid;
    endproperty
    a_rmc: assert property (p_rmc) else $error("counter read answer mistimed");
    property p_cp;
        s_cp |-> ##[2:40] (tx_out_ff.valid && (tx_out_ff.data == `COPY_DONE_BYTE || tx_out_ff.data == `IDLE_BYTE));
    endproperty
    a_cp: assert property (p_cp) else $error("copy reply missing");
    property p_hold;
        tx_out_ff.valid && !tx_ready && !bus_reset |=> tx_out_ff.valid && $stable(tx_out_ff.data);
    endproperty
    a_hold: assert property (p_hold) else $error("byte lost in stall");
    property p_skid;
        tx_out_ff.valid && tx_ready && !buf_ready_ff && !bus_reset |=> tx_out_ff.valid;
    endproperty
    a_skid: assert property (p_skid) else $error("second entry lost");
    property p_full;
        !buf_ready_ff |-> tx_out_ff.valid;
    endproperty
    a_full: assert property (p_full) else $error("full with empty head");
    property p_flush;
        bus_reset && tx_out_ff.valid |=> !tx_out_ff.valid [*2];
    endproperty
    a_flush: assert property (p_flush) else $error("no flush on bus reset");
    property p_quiet;
        $fell(srst) |-> !tx_out_ff.valid [*2];
    endproperty
    a_quiet: assert property (p_quiet) else $error("output before command");
endmodule : memfn_chk

// ### bench/bus_master_model.sv
// Master model: collects bytes from the read slots, with periodic and commanded stalls.
`timescale 1ns/10ps
module bus_master_model (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic hold,
    input wire memfn_pkg::tx_byte_t tx_out_ff,
    output logic tx_ready
);
    logic [7:0] q[$];
    logic [1:0] ph_ff = 2'h0;
    // One slot in four is stalled, and none is taken while held.
    assign tx_ready = !srst && !hold && (ph_ff != 2'h3);
    // Keeps issuing read slots for every byte offered, counter and CRC included.
    always @(posedge clk_sys) begin
        ph_ff <= ph_ff + 2'h1;
        if (tx_out_ff.valid && tx_ready) begin
            q.push_back(tx_out_ff.data);
        end
    end
endmodule : bus_master_model

// ### bench/paged_memory_counter_reader_test.sv
// Testbench for the paged memory layer, driven command by command.
`timescale 1ns/10ps
`include "memfn_regs.svh"
module paged_memory_counter_reader_test;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic bus_reset = 1'b0;
    logic hold = 1'b0;
    memfn_pkg::rx_byte_t rx_in = '0;
    logic tx_ready;
    memfn_pkg::tx_byte_t tx_out_ff;
    logic buf_ready_ff;
    logic [15:0] crc = 16'h0000;
    int n_errors = 0;
    int tests_run = 0;
    // Clock of 100 ns.
    always #50 clk_sys = ~clk_sys;
    paged_memory_counter_reader DUT (.clk_sys(clk_sys), .srst(srst), .bus_reset(bus_reset), .rx_in(rx_in),
        .tx_ready(tx_ready), .tx_out_ff(tx_out_ff), .buf_ready_ff(buf_ready_ff));
    bus_master_model u_mst (.clk_sys(clk_sys), .srst(srst), .hold(hold), .tx_out_ff(tx_out_ff),
        .tx_ready(tx_ready));
    // Page data pattern and CRC16 step, lsb first.
    function automatic logic [7:0] md(logic [8:0] a);
        return a[7:0] ^ 8'h5C;
    endfunction : md
    function automatic logic [15:0] cu(logic [15:0] c, logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ `CRC16_POLY_REV) : (c >> 1);
        end
        return c;
    endfunction : cu
    // Clock step, comparison, byte send and byte receive.
    task automatic tk;
        @(posedge clk_sys);
        #1;
    endtask : tk
    task automatic ck(logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : ck
    task automatic sb(logic [7:0] b);
        crc = cu(crc, b);
        rx_in = {1'b1, 1'b0, b};
        tk;
        rx_in = '0;
        tk;
    endtask : sb
    task automatic rb(logic [7:0] exp);
        logic [7:0] got;
        got = 8'hXX;
        for (int w = 0; w < 200 && u_mst.q.size() == 0; w++) begin
            tk;
        end
        if (u_mst.q.size() > 0) begin
            got = u_mst.q.pop_front();
        end
        crc = cu(crc, exp);
        ck(got, exp);
    endtask : rb
    // Inverted CRC, low byte first.
    task automatic rc;
        logic [15:0] e;
        e = ~crc;
        rb(e[7:0]);
        rb(e[15:8]);
    endtask : rc
    // Ends a transaction with a reset pulse and drops captured bytes.
    task automatic nr;
        bus_reset = 1'b1;
        tk;
        bus_reset = 1'b0;
        u_mst.q.delete();
        crc = `CRC16_CLEAR;
    endtask : nr
    task automatic cmd(logic [7:0] c, logic [8:0] a);
        nr;
        sb(c);
        sb(a[7:0]);
        sb({7'h00, a[8]});
    endtask : cmd
    // One page of a counter read: data to page end, counter, tamper bits and CRC.
    task automatic rp(logic [8:0] a, logic [31:0] c);
        do begin
            rb(md(a));
            a++;
        end while (a[4:0] != 5'h00);
        for (int i = 0; i < 4; i++) rb(c[8*i +: 8]);
        for (int i = 0; i < 4; i++) rb(8'h55);
        rc;
        crc = `CRC16_CLEAR;
    endtask : rp
    // Fills a page through the scratchpad, with a refused and an accepted copy.
    task automatic wp(logic [8:0] a);
        cmd(`CMD_WRITE_SP, a);
        for (int i = 0; i < 32; i++) sb(md(a + 9'(i)));
        rc;
        rb(`IDLE_BYTE);
        cmd(`CMD_COPY_SP, a);
        sb(8'h1E);
        rb(`IDLE_BYTE);
        cmd(`CMD_COPY_SP, a);
        sb(8'h1F);
        rb(`COPY_DONE_BYTE);
        nr;
        sb(`CMD_READ_SP);
        rb(a[7:0]);
        rb({7'h00, a[8]});
        rb(8'h9F);
        for (int i = 0; i < 32; i++) rb(md(a + 9'(i)));
        rb(`IDLE_BYTE);
    endtask : wp
    task automatic end_of_test;
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    // Main sequence.
    initial begin
        repeat (5) tk;
        srst = 1'b0;
        sb(`CMD_READ_SP);
        for (int i = 0; i < 3; i++) rb(8'h00);
        wp(9'h160);
        wp(9'h1C0);
        wp(9'h1E0);
        cmd(`CMD_READ_MEM_CTR, 9'h1DE);
        hold = 1'b1;
        repeat (8) tk;
        ck({7'h00, buf_ready_ff}, 8'h00);
        hold = 1'b0;
        rp(9'h1DE, 32'h00000001);
        rp(9'h1E0, 32'h00000001);
        rb(`IDLE_BYTE);
        rb(`IDLE_BYTE);
        cmd(`CMD_READ_MEM_CTR, 9'h17F);
        rp(9'h17F, `COUNTER_NONE);
        cmd(`CMD_READ_MEM, 9'h1FE);
        rb(md(9'h1FE));
        rb(md(9'h1FF));
        rb(`IDLE_BYTE);
        srst = 1'b1;
        tk;
        srst = 1'b0;
        u_mst.q.delete();
        sb(`CMD_READ_SP);
        for (int i = 0; i < 3; i++) rb(8'h00);
        end_of_test;
    end
    // Watchdog.
    initial begin
        #1000000;
        n_errors++;
        end_of_test;
    end
endmodule : paged_memory_counter_reader_test
bind paged_memory_counter_reader memfn_chk u_chk (.clk_sys(clk_sys), .srst(srst), .bus_reset(bus_reset),
    .rx_in(rx_in), .tx_ready(tx_ready), .tx_out_ff(tx_out_ff), .buf_ready_ff(buf_ready_ff));
